/* File: common/sor_params.svh */
// Timing counts and sizes for the safety output restart and test block.
// Assumes a 100 MHz system clock; included by the package and the design.
`ifndef SOR_PARAMS_SVH
`define SOR_PARAMS_SVH
`define SOR_NUM_OUT 4
`define SOR_NUM_SRC 16
`define SOR_CLK_MHZ 100
`define SOR_DIP_US 2
`define SOR_DIP_CYC (`SOR_DIP_US * `SOR_CLK_MHZ)
`define SOR_DIP_W 8
`define SOR_DIP_PERIOD_MS 10
`define SOR_DIP_PERIOD_CYC (`SOR_DIP_PERIOD_MS * 1000 * `SOR_CLK_MHZ)
`define SOR_RELAY_MS 12
`define SOR_RELAY_CYC (`SOR_RELAY_MS * 1000 * `SOR_CLK_MHZ)
`define SOR_LONG_W 21
`define SOR_DEB_US 10
`define SOR_DEB_CYC (`SOR_DEB_US * `SOR_CLK_MHZ)
`define SOR_DEB_W 10
`define SOR_SLOT_US 5
`define SOR_SLOT_CYC (`SOR_SLOT_US * `SOR_CLK_MHZ)
`define SOR_SLOT_W 9
`define SOR_TEST_RESET 4'he
`endif

/* File: common/sor_pkg.sv */
// Types for the safety output restart and test block.
// Assumes sor_params.svh is on the include path.
`include "sor_params.svh"
package sor_pkg;
  typedef enum logic [1:0] {
    SOR_RM_AUTO, SOR_RM_MANUAL, SOR_RM_MONITORED
  } sor_restart_e;
  typedef enum logic [1:0] {
    SOR_GRP_4SINGLE, SOR_GRP_2DUAL, SOR_GRP_DUAL_2SINGLE
  } sor_group_e;
  typedef enum logic [1:0] {
    SOR_RS_WAIT, SOR_RS_SAWHIGH, SOR_RS_GRANT
  } sor_rstate_e;
  typedef enum logic [1:0] {
    SOR_SRC_INPUT, SOR_SRC_OUTPUT, SOR_SRC_NODE
  } sor_src_e;
  typedef struct packed {
    sor_group_e group;
    sor_restart_e [`SOR_NUM_OUT-1:0] restart;
    logic [`SOR_NUM_OUT-1:0] relayAttached;
    sor_src_e statusSrc;
    logic [3:0] statusIdx;
  } sor_cfg_s;
  typedef struct packed {
    logic safeState;
    logic dipFault;
    logic relayFault;
    logic [`SOR_NUM_OUT-1:0] shortFault;
  } sor_fault_s;
endpackage : sor_pkg

/* File: verilog/sor_output_ctrl.sv */
// Safety output group: restart modes, dip test, short test, status pin.
// Assumes synchronous pins, one 100 MHz clock, static configuration.
//
// Behaviour
// - Status pin follows a selected input, output or logic node.
// - Short-test outputs pulse in turn; looped-back inputs must follow.
// - Each active safety output is dipped low briefly and checked.
// - Any dip test mismatch forces the whole block into safe state.
// - Dip test catches stuck low, stuck high and shorted outputs.
// - Four outputs group as 4 single, 2 dual or 1 dual plus 2 single.
// - Each channel has its own feedback input; dual drives two outputs.
// - Automatic restart: output on only while restart feedback is high.
// - Manual restart: output on only after feedback rising edge.
// - Monitored restart: output on only after a high-then-low pulse.
// - Relay contact monitored through its feedback contact.
// - Relay-fed outputs get the relay switching time added to checks.
`timescale 1ns/10ps
`include "sor_params.svh"
module sor_output_ctrl #(
  parameter int unsigned DIP_PERIOD_CYC = `SOR_DIP_PERIOD_CYC,
  parameter int unsigned RELAY_CYC = `SOR_RELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input sor_pkg::sor_cfg_s cfg,
  // Logic demand and restart feedback, one per channel head
  input wire logic [`SOR_NUM_OUT-1:0] logicDemand,
  input wire logic [`SOR_NUM_OUT-1:0] restartFbk,
  // Safety switching outputs and their readback
  output logic [`SOR_NUM_OUT-1:0] safetyOut,
  input wire logic [`SOR_NUM_OUT-1:0] safetyReadback,
  // Relay module feedback contacts
  input wire logic [`SOR_NUM_OUT-1:0] relayFbk,
  // Short test
  output logic [`SOR_NUM_OUT-1:0] testOut,
  input wire logic [`SOR_NUM_OUT-1:0] testIn,
  input wire logic [`SOR_NUM_OUT-1:0] shortClr,
  // Status indicator sources
  input wire logic [`SOR_NUM_SRC-1:0] genIn,
  input wire logic [`SOR_NUM_SRC-1:0] nodeIn,
  output logic statusOut,
  // Faults
  output sor_pkg::sor_fault_s fault
);
  localparam int N = `SOR_NUM_OUT;
  localparam logic [`SOR_LONG_W-1:0] PeriodLast =
    `SOR_LONG_W'(DIP_PERIOD_CYC - 1);
  localparam logic [`SOR_LONG_W-1:0] RelayDone =
    `SOR_LONG_W'(RELAY_CYC - 1);
  localparam logic [`SOR_DIP_W-1:0] DipLast = `SOR_DIP_W'(`SOR_DIP_CYC - 1);
  localparam logic [`SOR_DEB_W-1:0] DebLast = `SOR_DEB_W'(`SOR_DEB_CYC - 1);
  localparam logic [`SOR_SLOT_W-1:0] SlotLast =
    `SOR_SLOT_W'(`SOR_SLOT_CYC - 1);

  function automatic logic [1:0] headOf(input sor_pkg::sor_group_e g,
                                        input logic [1:0] o);
    case (g)
      sor_pkg::SOR_GRP_2DUAL: headOf = {o[1], 1'b0};
      sor_pkg::SOR_GRP_DUAL_2SINGLE: headOf = (o == 2'h1) ? 2'h0 : o;
      default: headOf = o;
    endcase
  endfunction : headOf

  logic [N-1:0] sync1_q, sync2_q, fbkStable_q, fbkPrev_q;
  logic [N-1:0] fbkRise, fbkFall, chanOn, want, wantPrev_q, dipMask;
  logic [N-1:0] safetyOut_q, outPrev_q, relayMismatch;
  logic [N-1:0] testOut_q, shortFault_q;
  logic [`SOR_DEB_W-1:0] debCnt_q [N];
  logic [`SOR_LONG_W-1:0] relCnt_q [N];
  logic [`SOR_LONG_W-1:0] periodCnt_q;
  logic [`SOR_DIP_W-1:0] dipCnt_q;
  logic [`SOR_SLOT_W-1:0] slotCnt_q;
  logic [1:0] dipIdx_q, slot_q;
  sor_pkg::sor_rstate_e rs_q [N];
  logic dipBusy_q, safe_q, dipFault_q, relayFault_q, statusOut_q;
  logic periodWrap, dipActive, checkNow, dipMismatch, relayErr, slotEnd;
  logic nodePick;

  // Two-flop sync, then the first flop is read by nothing else
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= restartFbk;
      sync2_q <= sync1_q;
    end
  end

  // Level must hold a full debounce window before it is believed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fbkStable_q <= '0;
      fbkPrev_q <= '0;
      for (int i = 0; i < N; i++) debCnt_q[i] <= '0;
    end else begin
      fbkPrev_q <= fbkStable_q;
      for (int i = 0; i < N; i++) begin
        if (sync2_q[i] == fbkStable_q[i]) begin
          debCnt_q[i] <= '0;
        end else if (debCnt_q[i] == DebLast) begin
          fbkStable_q[i] <= sync2_q[i];
          debCnt_q[i] <= '0;
        end else begin
          debCnt_q[i] <= debCnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign fbkRise = fbkStable_q & ~fbkPrev_q;
  assign fbkFall = ~fbkStable_q & fbkPrev_q;

  // Restart sequence per channel; losing demand re-arms it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < N; c++) rs_q[c] <= sor_pkg::SOR_RS_WAIT;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (!logicDemand[c] || safe_q) begin
          rs_q[c] <= sor_pkg::SOR_RS_WAIT;
        end else begin
          case (cfg.restart[c])
            sor_pkg::SOR_RM_MANUAL: begin
              if (rs_q[c] == sor_pkg::SOR_RS_WAIT && fbkRise[c])
                rs_q[c] <= sor_pkg::SOR_RS_GRANT;
            end
            sor_pkg::SOR_RM_MONITORED: begin
              if (rs_q[c] == sor_pkg::SOR_RS_WAIT && fbkRise[c])
                rs_q[c] <= sor_pkg::SOR_RS_SAWHIGH;
              else if (rs_q[c] == sor_pkg::SOR_RS_SAWHIGH && fbkFall[c])
                rs_q[c] <= sor_pkg::SOR_RS_GRANT;
            end
            default: rs_q[c] <= sor_pkg::SOR_RS_WAIT;
          endcase
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < N; c++) begin
      chanOn[c] = logicDemand[c] && !safe_q &&
        ((cfg.restart[c] == sor_pkg::SOR_RM_AUTO) ? fbkStable_q[c]
         : (rs_q[c] == sor_pkg::SOR_RS_GRANT));
    end
    for (int i = 0; i < N; i++) begin
      want[i] = chanOn[headOf(cfg.group, 2'(i))];
    end
  end

  // Dip test: one output at a time, only those currently on
  assign periodWrap = (periodCnt_q == PeriodLast);
  assign dipActive = dipBusy_q && want[dipIdx_q];
  assign dipMask = dipActive ? (4'h1 << dipIdx_q) : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) periodCnt_q <= '0;
    else periodCnt_q <= periodWrap ? '0 : periodCnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dipBusy_q <= 1'b0;
      dipIdx_q <= '0;
      dipCnt_q <= '0;
    end else if (periodWrap && !dipBusy_q) begin
      dipBusy_q <= 1'b1;
      dipIdx_q <= '0;
      dipCnt_q <= '0;
    end else if (dipBusy_q) begin
      if (dipActive && dipCnt_q != DipLast) begin
        dipCnt_q <= dipCnt_q + 1'b1;
      end else begin
        dipCnt_q <= '0;
        dipIdx_q <= dipIdx_q + 2'h1;
        if (dipIdx_q == 2'h3) dipBusy_q <= 1'b0;
      end
    end
  end

  // Sample only where the drive has settled; a switching edge is skipped
  assign checkNow = ((periodWrap && !dipBusy_q) ||
                     (dipActive && dipCnt_q == DipLast)) &&
                    (safetyOut_q == outPrev_q);
  assign dipMismatch = checkNow && (safetyReadback != safetyOut_q);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      safetyOut_q <= '0;
      outPrev_q <= '0;
    end else begin
      safetyOut_q <= want & ~dipMask;
      outPrev_q <= safetyOut_q;
    end
  end

  // Relay check waits out the relay switching time after each change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wantPrev_q <= '0;
      for (int i = 0; i < N; i++) relCnt_q[i] <= '0;
    end else begin
      wantPrev_q <= want;
      for (int i = 0; i < N; i++) begin
        if (want[i] != wantPrev_q[i]) relCnt_q[i] <= '0;
        else if (relCnt_q[i] != RelayDone)
          relCnt_q[i] <= relCnt_q[i] + 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      relayMismatch[i] = cfg.relayAttached[i] && relCnt_q[i] == RelayDone &&
        (relayFbk[i] == wantPrev_q[i]);
    end
  end
  assign relayErr = |relayMismatch;

  // Safe state is sticky; only a reset leaves it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      safe_q <= 1'b0;
      dipFault_q <= 1'b0;
      relayFault_q <= 1'b0;
    end else begin
      safe_q <= safe_q | dipMismatch | relayErr;
      dipFault_q <= dipFault_q | dipMismatch;
      relayFault_q <= relayFault_q | relayErr;
    end
  end

  // Short test: one line low per slot, each testIn is the wired
  // parallel group of inputs on that line
  assign slotEnd = (slotCnt_q == SlotLast);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slotCnt_q <= '0;
      slot_q <= '0;
      testOut_q <= `SOR_TEST_RESET;
    end else if (slotEnd) begin
      slotCnt_q <= '0;
      slot_q <= slot_q + 2'h1;
      testOut_q <= ~(4'h1 << (slot_q + 2'h1));
    end else begin
      slotCnt_q <= slotCnt_q + 1'b1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) shortFault_q <= '0;
    else shortFault_q <= (shortFault_q & ~shortClr) |
      ({N{slotEnd}} & (testIn ^ testOut_q));
  end

  assign nodePick = nodeIn[cfg.statusIdx];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      statusOut_q <= 1'b0;
    end else begin
      case (cfg.statusSrc)
        sor_pkg::SOR_SRC_INPUT: statusOut_q <= genIn[cfg.statusIdx];
        sor_pkg::SOR_SRC_OUTPUT:
          statusOut_q <= safetyOut_q[cfg.statusIdx[1:0]];
        sor_pkg::SOR_SRC_NODE: statusOut_q <= nodePick;
        default: statusOut_q <= 1'b0;
      endcase
    end
  end

  assign safetyOut = safetyOut_q;
  assign testOut = testOut_q;
  assign statusOut = statusOut_q;
  assign fault = '{safeState: safe_q, dipFault: dipFault_q,
                   relayFault: relayFault_q, shortFault: shortFault_q};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_status_node;
    cfg.statusSrc == sor_pkg::SOR_SRC_NODE |=> statusOut == $past(nodePick);
  endproperty
  a_status_node: assert property (p_status_node)
    else $error("status pin does not follow node");
  property p_test_walk;
    slotEnd |=> $countones(~testOut) == 1 && testOut != $past(testOut);
  endproperty
  a_test_walk: assert property (p_test_walk)
    else $error("short test pattern did not advance");
  property p_dip_low;
    $rose(dipActive) |=> ((safetyOut & dipMask) == 4'h0) [*8];
  endproperty
  a_dip_low: assert property (p_dip_low)
    else $error("dipped output not held low");
  property p_safe;
    dipMismatch |=> safe_q ##1 (safetyOut == 4'h0);
  endproperty
  a_safe: assert property (p_safe)
    else $error("mismatch did not reach safe state");
  property p_stuck;
    checkNow && (safetyReadback != safetyOut) |=> fault.dipFault;
  endproperty
  a_stuck: assert property (p_stuck)
    else $error("readback mismatch not flagged");
  property p_dual;
    cfg.group == sor_pkg::SOR_GRP_2DUAL |-> want[0] == want[1] &&
      want[2] == want[3];
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual channel halves disagree");
  property p_head;
    cfg.group == sor_pkg::SOR_GRP_DUAL_2SINGLE |-> want[1] == chanOn[0] &&
      want[3] == chanOn[3];
  endproperty
  a_head: assert property (p_head)
    else $error("output not tied to its channel");
  property p_auto;
    cfg.restart[0] == sor_pkg::SOR_RM_AUTO && !fbkStable_q[0] |-> !chanOn[0];
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic channel on without feedback");
  property p_manual;
    cfg.restart[0] == sor_pkg::SOR_RM_MANUAL &&
      rs_q[0] != sor_pkg::SOR_RS_GRANT && !fbkRise[0]
      |=> rs_q[0] != sor_pkg::SOR_RS_GRANT;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual grant without rising edge");
  property p_monitored;
    cfg.restart[0] == sor_pkg::SOR_RM_MONITORED &&
      rs_q[0] != sor_pkg::SOR_RS_GRANT && !fbkFall[0]
      |=> rs_q[0] != sor_pkg::SOR_RS_GRANT;
  endproperty
  a_monitored: assert property (p_monitored)
    else $error("monitored grant without falling edge");
  property p_relay;
    relayErr |=> fault.relayFault && fault.safeState;
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay feedback fault not flagged");
  property p_filter;
    $changed(fbkStable_q[0]) |-> $past(debCnt_q[0]) == DebLast;
  endproperty
  a_filter: assert property (p_filter)
    else $error("feedback changed before debounce");

  c_manual: cover property (cfg.restart[0] == sor_pkg::SOR_RM_MANUAL &&
                            rs_q[0] == sor_pkg::SOR_RS_GRANT);
  c_monitored: cover property (cfg.restart[0] == sor_pkg::SOR_RM_MONITORED &&
                               rs_q[0] == sor_pkg::SOR_RS_GRANT);
  c_dip_end: cover property (dipActive && dipCnt_q == DipLast);
  c_short: cover property (|shortFault_q);
endmodule : sor_output_ctrl

/* File: dv/sor_far_side_model.sv */
// Far side of the safety output group: loads, relay modules, test loops.
// Assumes the bench picks at most one injected wiring fault through flt.
`timescale 1ns/10ps
module sor_far_side_model #(
  parameter int RELAY_DLY = 250
) (
  // Clock
  input wire logic clk,
  // Block pins
  input wire logic [3:0] safetyOut,
  input wire logic [3:0] testOut,
  output logic [3:0] safetyReadback,
  output logic [3:0] relayFbk,
  output logic [3:0] testIn,
  // Fault: 1 low, 2 high, 3 short, 4 test short, 5 weld
  input wire logic [2:0] flt
);
  logic [3:0] last = 4'h0;
  logic [3:0] relayOn = 4'h0;
  int cnt[4] = '{0, 0, 0, 0};

  // Slower than a dip, faster than the relay check window
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (safetyOut[i] !== last[i]) begin
        last[i] <= safetyOut[i];
        cnt[i] <= 0;
      end else if (cnt[i] < RELAY_DLY) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        relayOn[i] <= last[i];
      end
    end
  end

  always_comb begin
    safetyReadback = safetyOut;
    relayFbk = ~relayOn;
    testIn = testOut;
    case (flt)
      3'h1: safetyReadback[0] = 1'b0;
      3'h2: safetyReadback[0] = 1'b1;
      3'h3: safetyReadback[1:0] = {2{|safetyOut[1:0]}};
      3'h4: testIn[2] = 1'b0;
      3'h5: relayFbk[0] = 1'b1;
      default: ;
    endcase
  end
endmodule : sor_far_side_model

/* File: dv/tb.sv */
// Bench for the safety output group with its far-side model.
// Assumes short dip and relay periods; debounce stays at 1000 cycles.
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  sor_pkg::sor_cfg_s cfg;
  logic [3:0] logicDemand, restartFbk, shortClr, safetyOut, relayFbk;
  logic [3:0] safetyReadback, testOut, testIn, d, e4;
  logic [15:0] genIn, nodeIn;
  logic statusOut, es;
  sor_pkg::sor_fault_s fault;
  logic [2:0] flt;
  logic [23:0] q[$];
  logic [23:0] note;
  logic [11:0] obs;
  logic [6:0] ef[6] = '{7'h00, 7'h60, 7'h60, 7'h60, 7'h04, 7'h50};
  int sinceHigh[4] = '{1000, 1000, 1000, 1000};
  int mismatches = 0;
  int check_count = 0;
  event chk;

  always #5 clk = ~clk;

  sor_output_ctrl #(.DIP_PERIOD_CYC(2000), .RELAY_CYC(300))
    sor_output_ctrl_inst (
    .clk(clk), .resetn(resetn), .cfg(cfg), .logicDemand(logicDemand),
    .restartFbk(restartFbk), .safetyOut(safetyOut),
    .safetyReadback(safetyReadback), .relayFbk(relayFbk), .testOut(testOut),
    .testIn(testIn), .shortClr(shortClr), .genIn(genIn), .nodeIn(nodeIn),
    .statusOut(statusOut), .fault(fault));

  sor_far_side_model sor_far_side_model_inst (
    .clk(clk), .safetyOut(safetyOut), .testOut(testOut),
    .safetyReadback(safetyReadback), .relayFbk(relayFbk), .testIn(testIn),
    .flt(flt));

  // Dips last 200 cycles, so an output counts as on if high lately
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      sinceHigh[i] <= safetyOut[i] ? 0 : (sinceHigh[i] < 1000 ?
        sinceHigh[i] + 1 : 1000);
    end
  end

  initial forever begin
    @(chk);
    note = q.pop_front();
    for (int i = 0; i < 4; i++) obs[i] = sinceHigh[i] < 250;
    obs[11:4] = {statusOut, fault};
    check_count++;
    if ((obs & note[23:12]) !== (note[11:0] & note[23:12])) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, obs, note[11:0]);
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic expect_out(input logic [11:0] m, input logic [11:0] v);
    q.push_back({m, v});
    -> chk;
    #0;
  endtask : expect_out

  task automatic expect_of(input logic [6:0] f, input logic [3:0] on);
    expect_out(12'h7ff, {1'b0, f, on});
  endtask : expect_of

  task automatic do_reset(input logic [2:0] f);
    resetn = 1'b0;
    flt = f;
    cyc(12);
    resetn = 1'b1;
  endtask : do_reset

  task automatic set_cfg(input sor_pkg::sor_group_e g);
    cfg.group = g;
    for (int i = 0; i < 4; i++) cfg.restart[i] = sor_pkg::SOR_RM_AUTO;
    cfg.relayAttached = 4'hf;
    cfg.statusSrc = sor_pkg::SOR_SRC_INPUT;
    cfg.statusIdx = 4'h0;
  endtask : set_cfg

  initial begin
    #1000000;
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(32'hc365));
    {flt, logicDemand, restartFbk, shortClr, genIn, nodeIn} = '0;
    set_cfg(sor_pkg::SOR_GRP_4SINGLE);
    cfg.restart[1] = sor_pkg::SOR_RM_MANUAL;
    cfg.restart[2] = sor_pkg::SOR_RM_MONITORED;
    do_reset(3'h0);
    logicDemand = 4'hf;
    cyc(1200);
    expect_of(7'h00, 4'h0);
    restartFbk = 4'h7;
    cyc(1200);
    expect_of(7'h00, 4'h3);
    restartFbk = 4'h8;
    cyc(500);
    restartFbk = 4'h0;
    cyc(1200);
    expect_of(7'h00, 4'h6);
    logicDemand[1] = 1'b0;
    cyc(5);
    logicDemand[1] = 1'b1;
    cyc(1200);
    expect_of(7'h00, 4'h4);
    $display("restart modes done");
    // Output sources pick idle outputs only, so dips never interfere
    for (int k = 0; k < 6; k++) begin
      cfg.statusSrc = sor_pkg::sor_src_e'(k % 3);
      cfg.statusIdx = 4'($urandom) & (k % 3 == 1 ? 4'h1 : 4'hf);
      genIn = 16'($urandom);
      nodeIn = 16'($urandom);
      cyc(3);
      es = k % 3 == 0 ? genIn[cfg.statusIdx] :
        (k % 3 == 2 ? nodeIn[cfg.statusIdx] : 1'b0);
      expect_out(12'h800, {es, 11'h0});
    end
    $display("status done");
    for (int g = 0; g < 3; g++) begin
      set_cfg(sor_pkg::sor_group_e'(g));
      d = 4'($urandom);
      logicDemand = d;
      restartFbk = 4'hf;
      do_reset(3'h0);
      cyc(1300);
      e4 = g == 0 ? d : (g == 1 ? {d[2], d[2], d[0], d[0]} :
        {d[3], d[2], d[0], d[0]});
      expect_of(7'h00, e4);
    end
    $display("groups done");
    set_cfg(sor_pkg::SOR_GRP_4SINGLE);
    for (int f = 1; f < 6; f++) begin
      logicDemand = 4'h1;
      do_reset(3'(f));
      cyc(4000);
      expect_of(ef[f], f == 4 ? 4'h1 : 4'h0);
      if (f == 4) begin
        flt = 3'h0;
        shortClr = 4'hf;
        cyc(1);
        shortClr = 4'h0;
        cyc(2100);
        expect_of(7'h00, 4'h1);
      end
    end
    $display("faults done");
    close_out();
  end
endmodule : tb
